// File: cpc_pkg.sv
// package of register map, fields and modes for the clock and power control block
package cpc_pkg;
  localparam logic [3:0] OFS_TRIM = 4'h0;
  localparam logic [3:0] OFS_AUX = 4'h4;
  localparam logic [3:0] OFS_PRND = 4'h8;
  localparam logic [3:0] OFS_OSC = 4'hC;
  localparam logic [3:0] OFS_PWR = 4'h0;
  localparam logic [1:0] ADDR_PAGE_LO = 2'h0;
  localparam int TRIM_W = 6;
  localparam logic [5:0] TRIM_RST = 6'h00;
  localparam int AUX_EN_BIT = 15;
  localparam int AUX_LOCK_BIT = 14;
  localparam int AUX_SRC_BIT = 13;
  localparam int AUX_DIV_LSB = 8;
  localparam int AUX_REF_BIT = 7;
  localparam int AUX_RC_BIT = 6;
  localparam logic [15:0] AUX_RST = 16'h2700;
  localparam logic [15:0] AUX_WMASK = 16'hA7C0;
  localparam logic [14:0] PRND_RST = 15'h0000;
  localparam int OSC_NEW_LSB = 8;
  localparam int OSC_CUR_LSB = 12;
  localparam int OSC_SWITCH_BIT = 0;
  localparam logic [2:0] OSC_RST = 3'h0;
  localparam int PWR_CORE_REG_BIT = 8;
  localparam int PWR_FLASH_REG_BIT = 11;
  localparam int PWR_SLEEP_FLAG_BIT = 3;
  localparam int PWR_IDLE_FLAG_BIT = 2;
  localparam int PWR_UNLOCK_BIT = 0;
  localparam int RESUME_NS = 100;
  localparam int CLK_NS = 50;
  localparam int RESUME_CYC = RESUME_NS / CLK_NS;
  localparam int AUX_LOCK_CYC = 64;
  typedef enum logic [3:0] {
    CPC_RUN = 4'b0001,
    CPC_SLEEP = 4'b0010,
    CPC_IDLE = 4'b0100,
    CPC_RESUME = 4'b1000
  } cpc_state_e;
endpackage

// File: cpc_clock_power.sv
// clock selection, auxiliary clock path, pseudorandom register and sleep/idle control
//
// Contract
// - six-bit signed trim code sets fast RC frequency around its centre
// - auxiliary PLL runs only while its enable bit is one
// - read-only lock bit reports auxiliary PLL lock; writes ignored
// - divider source: aux oscillators when one, primary PLL VCO when zero
// - output divider codes 111..000 divide by 1,2,4,8,16,32,64,256
// - reference select one routes primary oscillator; zero selects nothing
// - PLL input select one picks fast RC; zero follows reference select
// - pseudorandom register has 15 read-write bits, reset zero, top bit zero
// - sleep stops clocks and execution; idle halts only the CPU
// - sleep shuts system clock, on-chip oscillator and clock failure monitor
// - in sleep low-power RC runs whenever watchdog is enabled
// - watchdog is cleared on entry to sleep and to idle; the code clears on sleep entry only while watchdog_enable is set
// - sleep disables system-clocked peripherals; change notice keeps running
// - wake on enabled interrupt, any reset, or watchdog time-out
// - sleep wake restarts on the clock source active at entry
// - regulator keep-on bits clear put both regulators in standby in sleep
// - idle keeps system clock; low-power RC runs if watchdog or monitor on
// - idle wake reapplies CPU clock, execution resumes 2 to 4 cycles later
// - each peripheral's stop-in-idle bit stops it during idle
// - switch request bit starts an oscillator switch, cleared when done
`timescale 1ns/1ns
module cpc_clock_power
  import cpc_pkg::*;
#(
  parameter int NUM_PERIPH = 4,
  parameter int LOCK_CYCLES = AUX_LOCK_CYC,
  parameter int SWITCH_CYCLES = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [1:0] avs_page,
  input wire logic power_save_instruction,
  input wire logic power_save_sleep,
  input wire logic wake_interrupt,
  input wire logic watchdog_timeout,
  input wire logic watchdog_enable,
  input wire logic clock_failure_monitor_enable,
  input wire logic [NUM_PERIPH-1:0] stop_in_idle,
  input wire logic aux_osc_clk,
  input wire logic primary_osc_clk,
  input wire logic fast_rc_clk,
  input wire logic primary_vco_clk,
  output logic [TRIM_W-1:0] trim_code,
  output logic aux_pll_running,
  output logic aux_clock_out,
  output logic cpu_clock_enable,
  output logic system_clock_enable,
  output logic low_power_rc_enable,
  output logic clock_failure_monitor_active,
  output logic watchdog_clear,
  output logic core_regulator_standby,
  output logic flash_regulator_standby,
  output logic [NUM_PERIPH-1:0] periph_clock_enable,
  output logic [2:0] active_oscillator
);
  // one register page selector chooses between clock and power views
  logic [15:0] aux_ctrl;
  logic [14:0] pseudorandom_bits;
  logic [2:0] new_oscillator_select;
  logic oscillator_switch_request;
  logic core_regulator_keep_on;
  logic flash_regulator_keep_on;
  logic config_unlocked;
  logic aux_pll_locked;
  logic [7:0] lock_count;
  logic [7:0] switch_count;
  logic [7:0] aux_div_count;
  logic [1:0] resume_count;
  logic bus_ack;
  logic wr_req;
  logic rd_req;
  logic aux_ref_live;
  logic aux_src_clk;
  logic [7:0] aux_div_ratio;
  cpc_state_e state;
  cpc_state_e next_state;

  function automatic logic [7:0] div_ratio(input logic [2:0] code);
    logic [7:0] r;
    // half the division minus one; code 7 bypasses the counter
    r = 8'h7F;
    if (code == 3'h7) begin
      r = 8'h00;
    end else if (code != 3'h0) begin
      r = 8'((9'h001 << (3'h6 - code)) - 9'h001);
    end
    return r;
  endfunction

  function automatic logic page_hit(input logic [1:0] pg, input logic [3:0] a, input logic [3:0] o);
    return (pg == ADDR_PAGE_LO) && (a == o);
  endfunction

  // one wait cycle on every access keeps read data from a flop
  // a write lands only on the edge that sees waitrequest low
  assign wr_req = avs_write && bus_ack;
  assign rd_req = avs_read && !bus_ack;
  assign avs_waitrequest = (avs_read || avs_write) && !bus_ack;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bus_ack <= 1'b0;
    end else if (clk_en) begin
      bus_ack <= (avs_read || avs_write) && !bus_ack;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (clk_en && rd_req) begin
      avs_readdata <= 32'h0000_0000;
      if (avs_page == ADDR_PAGE_LO) begin
        case (avs_address)
          OFS_TRIM: avs_readdata <= {26'h0, trim_code};
          OFS_AUX: begin
            avs_readdata <= {16'h0, aux_ctrl};
            avs_readdata[AUX_LOCK_BIT] <= aux_pll_locked;
          end
          OFS_PRND: avs_readdata <= {17'h0, pseudorandom_bits};
          OFS_OSC: begin
            avs_readdata[OSC_CUR_LSB +: 3] <= active_oscillator;
            avs_readdata[OSC_NEW_LSB +: 3] <= new_oscillator_select;
            avs_readdata[OSC_SWITCH_BIT] <= oscillator_switch_request;
          end
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end else if (avs_address == OFS_PWR) begin
        avs_readdata[PWR_CORE_REG_BIT] <= core_regulator_keep_on;
        avs_readdata[PWR_FLASH_REG_BIT] <= flash_regulator_keep_on;
        avs_readdata[PWR_SLEEP_FLAG_BIT] <= (state == CPC_SLEEP);
        avs_readdata[PWR_IDLE_FLAG_BIT] <= (state == CPC_IDLE);
        avs_readdata[PWR_UNLOCK_BIT] <= config_unlocked;
      end
    end
  end

  // trim register: signed code, 0 centre, 01F max up, 20 max down
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      trim_code <= TRIM_RST;
    end else if (clk_en && wr_req && page_hit(avs_page, avs_address, OFS_TRIM)) begin
      trim_code <= avs_writedata[TRIM_W-1:0];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aux_ctrl <= AUX_RST;
    end else if (clk_en && wr_req && page_hit(avs_page, avs_address, OFS_AUX)) begin
      aux_ctrl <= avs_writedata[15:0] & AUX_WMASK;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pseudorandom_bits <= PRND_RST;
    end else if (clk_en && wr_req && page_hit(avs_page, avs_address, OFS_PRND)) begin
      pseudorandom_bits <= avs_writedata[14:0];
    end
  end

  // power page: regulator keep-on bits and configuration unlock
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      core_regulator_keep_on <= 1'b0;
      flash_regulator_keep_on <= 1'b0;
      config_unlocked <= 1'b0;
    end else if (clk_en && wr_req && avs_page != ADDR_PAGE_LO && avs_address == OFS_PWR) begin
      core_regulator_keep_on <= avs_writedata[PWR_CORE_REG_BIT];
      flash_regulator_keep_on <= avs_writedata[PWR_FLASH_REG_BIT];
      config_unlocked <= avs_writedata[PWR_UNLOCK_BIT];
    end
  end

  // oscillator selection; a locked configuration ignores the write
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      new_oscillator_select <= OSC_RST;
      oscillator_switch_request <= 1'b0;
      switch_count <= 8'h00;
      active_oscillator <= OSC_RST;
    end else if (clk_en) begin
      if (wr_req && config_unlocked && page_hit(avs_page, avs_address, OFS_OSC)) begin
        new_oscillator_select <= avs_writedata[OSC_NEW_LSB +: 3];
        if (avs_writedata[OSC_SWITCH_BIT]) begin
          oscillator_switch_request <= 1'b1;
          switch_count <= 8'h00;
        end
      end else if (oscillator_switch_request && state != CPC_SLEEP) begin
        if (switch_count == 8'(SWITCH_CYCLES - 1)) begin
          active_oscillator <= new_oscillator_select;
          oscillator_switch_request <= 1'b0;
        end else begin
          switch_count <= switch_count + 8'h01;
        end
      end
    end
  end

  // aux reference: fast RC wins, else primary osc, else nothing
  assign aux_ref_live = aux_ctrl[AUX_RC_BIT] || aux_ctrl[AUX_REF_BIT];
  assign aux_pll_running = aux_ctrl[AUX_EN_BIT] && aux_ref_live;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      lock_count <= 8'h00;
      aux_pll_locked <= 1'b0;
    end else if (clk_en) begin
      if (!aux_pll_running) begin
        lock_count <= 8'h00;
        aux_pll_locked <= 1'b0;
      end else if (lock_count == 8'(LOCK_CYCLES - 1)) begin
        aux_pll_locked <= 1'b1;
      end else begin
        lock_count <= lock_count + 8'h01;
      end
    end
  end

  // source clocks arrive as synchronous levels; divider toggles on their state
  always_comb begin
    aux_src_clk = 1'b0;
    if (!aux_ctrl[AUX_SRC_BIT]) begin
      aux_src_clk = primary_vco_clk;
    end else if (aux_ctrl[AUX_RC_BIT]) begin
      aux_src_clk = fast_rc_clk;
    end else if (aux_ctrl[AUX_REF_BIT]) begin
      aux_src_clk = primary_osc_clk || aux_osc_clk;
    end
  end
  assign aux_div_ratio = div_ratio(aux_ctrl[AUX_DIV_LSB +: 3]);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aux_div_count <= 8'h00;
      aux_clock_out <= 1'b0;
    end else if (clk_en) begin
      if (!aux_ref_live) begin
        aux_div_count <= 8'h00;
        aux_clock_out <= 1'b0;
      end else if (aux_ctrl[AUX_DIV_LSB +: 3] == 3'h7) begin
        // divide by one: a registered copy of the selected source
        aux_div_count <= 8'h00;
        aux_clock_out <= aux_src_clk;
      end else if (aux_src_clk) begin
        if (aux_div_count >= aux_div_ratio) begin
          aux_div_count <= 8'h00;
          aux_clock_out <= !aux_clock_out;
        end else begin
          aux_div_count <= aux_div_count + 8'h01;
        end
      end
    end
  end

  // power-save sequencer
  always_comb begin
    next_state = state;
    case (state)
      CPC_RUN: begin
        if (power_save_instruction) begin
          next_state = power_save_sleep ? CPC_SLEEP : CPC_IDLE;
        end
      end
      CPC_SLEEP: begin
        if (wake_interrupt || watchdog_timeout) begin
          next_state = CPC_RESUME;
        end
      end
      CPC_IDLE: begin
        if (wake_interrupt || watchdog_timeout) begin
          next_state = CPC_RESUME;
        end
      end
      CPC_RESUME: begin
        if (resume_count == 2'(RESUME_CYC - 1)) begin
          next_state = CPC_RUN;
        end
      end
      default: next_state = CPC_RUN;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= CPC_RUN;
      resume_count <= 2'h0;
    end else if (clk_en) begin
      state <= next_state;
      resume_count <= (state == CPC_RESUME) ? resume_count + 2'h1 : 2'h0;
    end
  end

  // watchdog clear pulse on the entry edge into idle, and into sleep only while watchdog_enable is set
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      watchdog_clear <= 1'b0;
    end else if (clk_en) begin
      watchdog_clear <= (state == CPC_RUN) && power_save_instruction &&
                        (watchdog_enable || !power_save_sleep);
    end
  end

  // active_oscillator is untouched during sleep, so wake reuses it
  assign system_clock_enable = (state != CPC_SLEEP);
  assign cpu_clock_enable = (state == CPC_RUN);
  assign clock_failure_monitor_active = clock_failure_monitor_enable &&
                                        (state != CPC_SLEEP);
  assign low_power_rc_enable = watchdog_enable ||
                               (clock_failure_monitor_enable && state != CPC_SLEEP);
  assign core_regulator_standby = (state == CPC_SLEEP) && !core_regulator_keep_on;
  assign flash_regulator_standby = (state == CPC_SLEEP) && !flash_regulator_keep_on;
  always_comb begin
    for (int i = 0; i < NUM_PERIPH; i++) begin
      periph_clock_enable[i] = (state != CPC_SLEEP) &&
                               !(state == CPC_IDLE && stop_in_idle[i]);
    end
  end

  property p_sleep_entry;
    @(posedge clk_sys) disable iff (!rst_n)
    (clk_en && state == CPC_RUN && power_save_instruction && power_save_sleep)
      |=> (state == CPC_SLEEP) && !system_clock_enable;
  endproperty
  sleep_entry_a: assert property (p_sleep_entry) else $error("sleep not entered");

  idle_entry_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && state == CPC_RUN && power_save_instruction && !power_save_sleep)
      |=> cpu_clock_enable == 1'b0 && system_clock_enable) else $error("idle wrong");

  wdt_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && state == CPC_RUN && power_save_instruction && !power_save_sleep)
      |=> watchdog_clear) else $error("watchdog not cleared");

  sequence s_wake;
    clk_en && (state == CPC_IDLE) && wake_interrupt;
  endsequence
  sequence s_resume;
    !cpu_clock_enable [*3] ##1 cpu_clock_enable;
  endsequence
  idle_resume_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_wake ##1 clk_en [*2] |-> $past(cpu_clock_enable) == 1'b0 ##1 cpu_clock_enable)
    else $error("resume delay wrong");
  wake_seq_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_wake |-> s_resume or (##[1:4] !clk_en)) else $error("no wake");

  lock_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && !aux_ref_live) |=> !aux_pll_locked) else $error("lock without reference");

  prnd_top_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (avs_read && !avs_waitrequest && $past(avs_address) == OFS_PRND &&
     $past(avs_page) == ADDR_PAGE_LO) |-> avs_readdata[15] == 1'b0)
    else $error("prnd top bit set");

  regulator_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == CPC_SLEEP && !core_regulator_keep_on) |-> core_regulator_standby)
    else $error("regulator not in standby");

  flash_standby_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (state == CPC_SLEEP) |-> flash_regulator_standby == !flash_regulator_keep_on)
    else $error("flash regulator wrong");

  lock_drop_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && !aux_pll_running) |=> !aux_pll_locked) else $error("lock while stopped");

  switch_done_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $fell(oscillator_switch_request) |-> active_oscillator == new_oscillator_select)
    else $error("switch incomplete");
endmodule

// File: cpc_clock_power_bench.sv
// self-checking bench for the clock and power control block
`timescale 1ns/1ns
module cpc_clock_power_bench;
  import cpc_pkg::*;
  typedef struct {logic [1:0] pg; logic [3:0] a; logic [31:0] d; logic [31:0] e;} cpc_row_s;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [1:0] avs_page = 2'h0;
  logic ps_go = 1'b0;
  logic ps_sleep = 1'b0;
  logic wake_irq = 1'b0;
  logic wdt_to = 1'b0;
  logic wdt_en = 1'b0;
  logic mon_en = 1'b0;
  logic [3:0] stop_idle = 4'h0;
  logic src = 1'b0;
  // vco held high so its divided rate differs from the toggling sources
  logic vco = 1'b1;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [5:0] trim_code;
  logic pll_run, aux_out, cpu_en, sys_en, low_power_rc_oscillator_en, mon_act, wdt_clr, core_sb, flash_sb, last;
  logic [3:0] periph_en;
  logic [2:0] act_osc;
  logic [10:0] pv;
  logic [31:0] rd;
  int error_cnt = 0;
  int checks_done = 0;
  int n, c4, c8;
  cpc_row_s rows[6] = '{
    '{2'h0, OFS_TRIM, 32'hFFFF_FFFF, 32'h0000_003F},
    '{2'h0, OFS_TRIM, 32'h0000_0020, 32'h0000_0020},
    '{2'h0, OFS_PRND, 32'hFFFF_FFFF, 32'h0000_7FFF},
    '{2'h0, OFS_PRND, 32'h0000_1234, 32'h0000_1234},
    '{2'h0, OFS_AUX, 32'h0000_4740, 32'h0000_0740},
    '{2'h1, 4'h4, 32'h0000_5A5A, 32'h0000_0000}};

  assign pv = {cpu_en, sys_en, low_power_rc_oscillator_en, mon_act, wdt_clr, core_sb, flash_sb, periph_en};

  always #25 clk_sys = ~clk_sys;
  // the aux, primary and fast RC sources toggle so that the divider has edges; the pll locks on register bits alone
  always @(posedge clk_sys) src <= ~src;

  cpc_clock_power #(.NUM_PERIPH(4), .LOCK_CYCLES(4), .SWITCH_CYCLES(2)) dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(1'b1), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_page(avs_page),
    .power_save_instruction(ps_go), .power_save_sleep(ps_sleep), .wake_interrupt(wake_irq),
    .watchdog_timeout(wdt_to), .watchdog_enable(wdt_en),
    .clock_failure_monitor_enable(mon_en), .stop_in_idle(stop_idle), .aux_osc_clk(src),
    .primary_osc_clk(src), .fast_rc_clk(src), .primary_vco_clk(vco), .trim_code(trim_code),
    .aux_pll_running(pll_run), .aux_clock_out(aux_out), .cpu_clock_enable(cpu_en),
    .system_clock_enable(sys_en), .low_power_rc_enable(low_power_rc_oscillator_en),
    .clock_failure_monitor_active(mon_act), .watchdog_clear(wdt_clr),
    .core_regulator_standby(core_sb), .flash_regulator_standby(flash_sb),
    .periph_clock_enable(periph_en), .active_oscillator(act_osc));

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task conclude;
    $display("errors %0d, checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // request held until the edge that samples waitrequest low; hangs end at the watchdog
  task bus(input logic w, input logic [1:0] pg, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    avs_page <= pg;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= ~w;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task rdc(input logic [1:0] pg, input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, pg, a, 32'h0);
    chk(rd, e);
  endtask

  task enter(input logic slp);
    @(posedge clk_sys);
    ps_sleep <= slp;
    ps_go <= 1'b1;
    @(posedge clk_sys);
    ps_go <= 1'b0;
    @(negedge clk_sys);
  endtask

  task wake(input logic by_wdt);
    int k;
    @(posedge clk_sys);
    if (by_wdt)
      wdt_to <= 1'b1;
    else
      wake_irq <= 1'b1;
    @(posedge clk_sys);
    wdt_to <= 1'b0;
    wake_irq <= 1'b0;
    k = 1;
    @(negedge clk_sys);
    while (cpu_en !== 1'b1 && k < 8) begin
      @(negedge clk_sys);
      k++;
    end
    chk(32'(k >= 2 && k <= 4), 32'h1);
  endtask

  task edges(output int c);
    c = 0;
    last = aux_out;
    repeat (128) begin
      @(negedge clk_sys);
      if (aux_out !== last) c++;
      last = aux_out;
    end
  endtask

  initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys);
    chk(32'({cpu_en, sys_en}), 32'h3);
    rdc(2'h0, OFS_TRIM, 32'h0);
    rdc(2'h0, OFS_AUX, 32'h0000_2700);
    rdc(2'h0, OFS_PRND, 32'h0);
    rdc(2'h0, OFS_OSC, 32'h0);
    foreach (rows[i]) begin
      bus(1'b1, rows[i].pg, rows[i].a, rows[i].d);
      rdc(rows[i].pg, rows[i].a, rows[i].e);
      if (rows[i].a == OFS_TRIM && rows[i].pg == 2'h0)
        chk(32'(trim_code), rows[i].e);
    end
    // selection is refused while locked, then switched once unlocked
    bus(1'b1, 2'h0, OFS_OSC, 32'h0000_0301);
    rdc(2'h0, OFS_OSC, 32'h0);
    bus(1'b1, 2'h1, OFS_PWR, 32'h0000_0001);
    bus(1'b1, 2'h0, OFS_OSC, 32'h0000_0301);
    n = 0;
    do begin
      bus(1'b0, 2'h0, OFS_OSC, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 20);
    chk(rd, 32'h0000_3300);
    chk(32'(act_osc), 32'h3);
    bus(1'b1, 2'h0, OFS_AUX, 32'h0000_8080);
    @(negedge clk_sys);
    chk(32'(pll_run), 32'h1);
    repeat (8) @(posedge clk_sys);
    rdc(2'h0, OFS_AUX, 32'h0000_C080);
    bus(1'b1, 2'h0, OFS_AUX, 32'h0000_8040);
    repeat (8) @(posedge clk_sys);
    rdc(2'h0, OFS_AUX, 32'h0000_C040);
    bus(1'b1, 2'h0, OFS_AUX, 32'h0000_0080);
    rdc(2'h0, OFS_AUX, 32'h0000_0080);
    chk(32'(pll_run), 32'h0);
    bus(1'b1, 2'h0, OFS_AUX, 32'h0000_8000);
    repeat (8) @(posedge clk_sys);
    rdc(2'h0, OFS_AUX, 32'h0000_8000);
    edges(n);
    chk(32'(n), 32'h0);
    // divide by 4 must give twice the edges of divide by 8, phase slack of two
    bus(1'b1, 2'h0, OFS_AUX, 32'h0000_2580);
    edges(c4);
    chk(32'(c4 >= 31 && c4 <= 33), 32'h1);
    bus(1'b1, 2'h0, OFS_AUX, 32'h0000_2480);
    edges(c8);
    chk(32'(c8 >= 15 && c8 <= 17), 32'h1);
    chk(32'(c8 > 0 && c4 >= 2 * c8 - 2 && c4 <= 2 * c8 + 2), 32'h1);
    // vco is high every cycle, so the same divide gives twice the edges
    bus(1'b1, 2'h0, OFS_AUX, 32'h0000_0480);
    edges(n);
    chk(32'(n >= 31 && n <= 33), 32'h1);
    bus(1'b1, 2'h0, OFS_AUX, 32'h0000_2780);
    edges(n);
    chk(32'(n >= 127), 32'h1);
    @(posedge clk_sys);
    stop_idle <= 4'b0101;
    mon_en <= 1'b1;
    enter(1'b0);
    chk(32'({cpu_en, sys_en, low_power_rc_oscillator_en, wdt_clr, periph_en}), 32'h7A);
    rdc(2'h1, OFS_PWR, 32'h0000_0005);
    wake(1'b1);
    @(posedge clk_sys);
    wdt_en <= 1'b1;
    enter(1'b1);
    chk(32'(pv), 32'h170);
    wake(1'b0);
    chk(32'(act_osc), 32'h3);
    bus(1'b1, 2'h1, OFS_PWR, 32'h0000_0901);
    wdt_en <= 1'b0;
    enter(1'b1);
    chk(32'(pv & 11'h6FF), 32'h0);
    rdc(2'h1, OFS_PWR, 32'h0000_0909);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    @(negedge clk_sys);
    chk(32'({cpu_en, sys_en}), 32'h3);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    rdc(2'h0, OFS_OSC, 32'h0);
    conclude;
  end

  initial begin
    #2_000_000;
    error_cnt++;
    conclude;
  end
endmodule
